// ---- core/die_link_port_cfg.svh ----
/*
  Constants for the die link port pins block: register indices, field
  widths, reset values and the APB answer codes.
  Assumes it is included by its bare name from the package and the core.
*/
// What this block does
// - Port C bit 1 becomes the die link interrupt input while the die link owns it.
// - Port C bit 0 becomes the die link clock output while the die link owns it.
// - In eight-bit die link mode all port D pins 7 to 0 carry die link data.
// - In four-bit die link mode only port D pins 3 to 0 carry die link data.
// - A data bit reads the stored value when its direction bit is 1, else the synced pin.
// - While the die link owns a pin it sets the direction and the stored bit stays unchanged.
// - A general purpose pin drives out when its direction bit is 1, else it floats as input.
// - Every port C or D pin the die link does not claim works as general purpose I/O.
// - The port C direction register holds only bits 1 and 0.
// - The port D direction register holds all eight bits 7 to 0.
// - Each byte of the reserved range reads as zero and ignores writes.
// - A data write moves a pin only when that pin is a general purpose output.
// - Port D pins get pull-downs while they serve as die link inputs.
// - In four-bit die link mode port D pins 7 to 4 stay general purpose I/O.
`ifndef DIE_LINK_PORT_CFG_SVH
`define DIE_LINK_PORT_CFG_SVH

// Register indices; byte address is four times the index
`define IDX_PORT_C_DATA 10'h004
`define IDX_PORT_D_DATA 10'h005
`define IDX_PORT_C_DIR 10'h006
`define IDX_PORT_D_DIR 10'h007
`define IDX_RSVD_FIRST 10'h008
`define IDX_RSVD_LAST 10'h019

// Widths
`define PORT_C_BITS 2
`define PORT_D_BITS 8
`define ADDR_BITS 12
`define NARROW_BITS_DEFAULT 4

// Reset values
`define RST_PORT_C 2'h0
`define RST_PORT_D 8'h00

// Bus answer pieces
`define WORD_LSB 2
`define ALIGN_OK 2'h0
`define RDATA_ZERO 32'h0000_0000
`define PAD_C 30'h0000_0000
`define PAD_D 24'h00_0000

`endif

// ---- core/die_link_port_pins.sv ----
/*
  Port C and port D general purpose I/O whose pins are shared with the
  die link interface, with the data and direction registers on APB.
  Assumes the die link logic runs on clk_sys, and that pin levels come
  from outside the clock domain.
*/
// Register access over APB was chosen for this implementation.
`default_nettype none

`include "die_link_port_cfg.svh"

module die_link_port_pins
  import die_link_port_pkg::*;
#(
  parameter int NARROW_BITS = `NARROW_BITS_DEFAULT
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_BITS-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port C pins
  input wire logic [`PORT_C_BITS-1:0] pc_in,
  output logic [`PORT_C_BITS-1:0] pc_out,
  output logic [`PORT_C_BITS-1:0] pc_oe,
  output logic pc1_pulldown,
  // Port D pins
  input wire logic [`PORT_D_BITS-1:0] pd_in,
  output logic [`PORT_D_BITS-1:0] pd_out,
  output logic [`PORT_D_BITS-1:0] pd_oe,
  output logic [`PORT_D_BITS-1:0] pd_pulldown,
  // Die link side
  input wire logic die_link_enable,
  input wire logic die_link_wide_mode,
  input wire logic die_link_clock,
  input wire logic [`PORT_D_BITS-1:0] die_link_data_out,
  input wire logic [`PORT_D_BITS-1:0] die_link_data_oe,
  output logic die_link_interrupt,
  output logic [`PORT_D_BITS-1:0] die_link_data_in
);

  // Narrow mode cannot claim more pins than the port has
  if (NARROW_BITS < 1 || NARROW_BITS > `PORT_D_BITS) begin : g_bad_narrow
    $error("NARROW_BITS must lie between 1 and the port D width");
  end

  port_state_t st;
  port_state_t next_st;

  logic [9:0] word_index;
  logic aligned;
  logic access_done;
  logic [`PORT_D_BITS-1:0] narrow_mask;
  logic [`PORT_D_BITS-1:0] d_owned;

  assign word_index = paddr[`ADDR_BITS-1:`WORD_LSB];
  assign aligned = (paddr[`WORD_LSB-1:0] == `ALIGN_OK);
  // Write lands and read data is taken only at this edge
  assign access_done = psel && penable && st.pready;

  // Pins claimed on port D by the die link, per width mode
  genvar gi;
  for (gi = 0; gi < `PORT_D_BITS; gi++) begin : g_mask
    assign narrow_mask[gi] = (gi < NARROW_BITS);
    // Eight-bit mode takes all pins, four-bit mode only the low ones
    assign d_owned[gi] = die_link_enable && (die_link_wide_mode || narrow_mask[gi]);
  end

  // Next state: synchronisers, bus slave and pin muxing
  always_comb begin
    next_st = st;

    // Pins enter through two flops; only the second stage is used below
    next_st.c_sync1 = pc_in;
    next_st.c_sync2 = st.c_sync1;
    next_st.d_sync1 = pd_in;
    next_st.d_sync2 = st.d_sync1;

    // Answer one cycle into the access phase, then drop after completion
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    if (psel && penable && !st.pready) begin
      next_st.pready = 1'b1;
      next_st.prdata = `RDATA_ZERO;
      if (!aligned) begin
        next_st.pslverr = 1'b1;
      end else if (word_index == `IDX_PORT_C_DATA) begin
        // Per bit: stored value for outputs, synced pin for inputs
        next_st.prdata = {`PAD_C, (st.port_c_direction & st.port_c_output_data) |
                          (~st.port_c_direction & st.c_sync2)};
      end else if (word_index == `IDX_PORT_D_DATA) begin
        next_st.prdata = {`PAD_D, (st.port_d_direction & st.port_d_output_data) |
                          (~st.port_d_direction & st.d_sync2)};
      end else if (word_index == `IDX_PORT_C_DIR) begin
        next_st.prdata = {`PAD_C, st.port_c_direction};
      end else if (word_index == `IDX_PORT_D_DIR) begin
        next_st.prdata = {`PAD_D, st.port_d_direction};
      end else if (word_index >= `IDX_RSVD_FIRST && word_index <= `IDX_RSVD_LAST) begin
        next_st.prdata = `RDATA_ZERO;
      end else begin
        next_st.pslverr = 1'b1;
      end
    end

    // Writes take only byte lane 0; reserved bytes swallow writes
    if (access_done && pwrite && pstrb[0] && aligned) begin
      if (word_index == `IDX_PORT_C_DATA) begin
        next_st.port_c_output_data = pwdata[`PORT_C_BITS-1:0];
      end else if (word_index == `IDX_PORT_D_DATA) begin
        next_st.port_d_output_data = pwdata[`PORT_D_BITS-1:0];
      end else if (word_index == `IDX_PORT_C_DIR) begin
        // Upper bits are not stored at all
        next_st.port_c_direction = pwdata[`PORT_C_BITS-1:0];
      end else if (word_index == `IDX_PORT_D_DIR) begin
        next_st.port_d_direction = pwdata[`PORT_D_BITS-1:0];
      end
    end

    // Port C bit 0: die link clock out, else general purpose
    if (die_link_enable) begin
      next_st.pc_out[0] = die_link_clock;
      next_st.pc_oe[0] = 1'b1;
    end else begin
      next_st.pc_out[0] = st.port_c_output_data[0];
      next_st.pc_oe[0] = st.port_c_direction[0];
    end

    // Port C bit 1: die link interrupt in, held with a pull-down
    if (die_link_enable) begin
      next_st.pc_out[1] = 1'b0;
      next_st.pc_oe[1] = 1'b0;
      next_st.pc1_pulldown = 1'b1;
    end else begin
      next_st.pc_out[1] = st.port_c_output_data[1];
      next_st.pc_oe[1] = st.port_c_direction[1];
      next_st.pc1_pulldown = 1'b0;
    end
    // Interrupt seen only while owned; a floating GPIO must not look like one
    next_st.die_link_interrupt = die_link_enable && st.c_sync2[1];

    // Port D: per pin select between die link and general purpose use
    for (int i = 0; i < `PORT_D_BITS; i++) begin
      if (d_owned[i]) begin
        // The die link steers direction; the stored bit is left alone
        next_st.pd_out[i] = die_link_data_out[i];
        next_st.pd_oe[i] = die_link_data_oe[i];
        next_st.pd_pulldown[i] = !die_link_data_oe[i];
      end else begin
        // Unclaimed pins, including the upper half in narrow mode
        next_st.pd_out[i] = st.port_d_output_data[i];
        next_st.pd_oe[i] = st.port_d_direction[i];
        next_st.pd_pulldown[i] = 1'b0;
      end
    end
    // Unclaimed bits read zero toward the die link
    next_st.die_link_data_in = d_owned & st.d_sync2;
  end

  // State register; every pin starts as a floating input
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
      st.port_c_output_data <= `RST_PORT_C;
      st.port_c_direction <= `RST_PORT_C;
      st.port_d_output_data <= `RST_PORT_D;
      st.port_d_direction <= `RST_PORT_D;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state flops
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign pc_out = st.pc_out;
  assign pc_oe = st.pc_oe;
  assign pc1_pulldown = st.pc1_pulldown;
  assign pd_out = st.pd_out;
  assign pd_oe = st.pd_oe;
  assign pd_pulldown = st.pd_pulldown;
  assign die_link_interrupt = st.die_link_interrupt;
  assign die_link_data_in = st.die_link_data_in;

endmodule // die_link_port_pins

`default_nettype wire

// ---- core/die_link_port_pkg.sv ----
/*
  Types for the die link port pins block: the single state record.
  Assumes the constants header sits beside it on the include path.
*/
`default_nettype none

package die_link_port_pkg;
`include "die_link_port_cfg.svh"

  // Whole state of the block, registered in one process
  typedef struct packed {
    logic [`PORT_C_BITS-1:0] port_c_output_data;
    logic [`PORT_C_BITS-1:0] port_c_direction;
    logic [`PORT_D_BITS-1:0] port_d_output_data;
    logic [`PORT_D_BITS-1:0] port_d_direction;
    logic [`PORT_C_BITS-1:0] c_sync1;
    logic [`PORT_C_BITS-1:0] c_sync2;
    logic [`PORT_D_BITS-1:0] d_sync1;
    logic [`PORT_D_BITS-1:0] d_sync2;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [`PORT_C_BITS-1:0] pc_out;
    logic [`PORT_C_BITS-1:0] pc_oe;
    logic pc1_pulldown;
    logic [`PORT_D_BITS-1:0] pd_out;
    logic [`PORT_D_BITS-1:0] pd_oe;
    logic [`PORT_D_BITS-1:0] pd_pulldown;
    logic die_link_interrupt;
    logic [`PORT_D_BITS-1:0] die_link_data_in;
  } port_state_t;

endpackage : die_link_port_pkg

`default_nettype wire

// ---- sim/die_link_far_model.sv ----
/* Far side: die link source and the port C and D wires.
   Assumes the bench gives what outside parties drive. */
`default_nettype none
module die_link_far_model (
  // Clock, reset, bench control
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic die_link_enable,
  input wire logic [1:0] far_c,
  input wire logic [7:0] far_d,
  // Device pins
  input wire logic [1:0] pc_out,
  input wire logic [1:0] pc_oe,
  input wire logic [7:0] pd_out,
  input wire logic [7:0] pd_oe,
  output logic [1:0] pc_in,
  output logic [7:0] pd_in,
  // Die link toward the device
  output logic die_link_clock,
  output logic [7:0] die_link_data_out,
  output logic [7:0] die_link_data_oe
);
  logic [7:0] cnt;
  // Runs only while enabled, so the link clock stands still outside frames
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) cnt <= 8'h00;
    else if (die_link_enable) cnt <= cnt + 8'h01;
  end
  assign die_link_clock = die_link_enable & cnt[0];
  assign die_link_data_out = cnt;
  assign die_link_data_oe = {8{cnt[3]}}; // Direction flips every eight cycles
  // Device drive wins; otherwise the outside party sets the level
  assign pc_in = (pc_oe & pc_out) | (~pc_oe & far_c);
  assign pd_in = (pd_oe & pd_out) | (~pd_oe & far_d);
endmodule // die_link_far_model
`default_nettype wire

// ---- sim/die_link_port_pins_tb_top.sv ----
/* Bench for die_link_port_pins: APB tasks and scenarios.
   Assumes the far model and the bound checker. */
`default_nettype none
module die_link_port_pins_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] c_dat = 12'h010, d_dat = 12'h014, c_dir = 12'h018, d_dir = 12'h01c;
  logic clk_sys = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic die_link_enable = 1'b0, die_link_wide_mode = 1'b0;
  logic pready, pslverr, pc1_pulldown, die_link_interrupt, die_link_clock;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'hf;
  logic [1:0] pc_in, pc_out, pc_oe, far_c = 2'h0;
  logic [7:0] pd_in, pd_out, pd_oe, pd_pulldown, far_d = 8'h00;
  logic [7:0] die_link_data_out, die_link_data_oe, die_link_data_in;
  int fails = 0, total_checks = 0;
  die_link_port_pins dut (.*);
  die_link_far_model far (.*);
  always #25 clk_sys = ~clk_sys;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One transfer; the request holds until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    // Ends when pready is seen; if it never comes only the watchdog ends this wait
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk({31'h0, e}, 32'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic ex = 1'b0);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    if (!ex) chk(r, x);
    chk({31'h0, e}, {31'h0, ex});
  endtask
  // Pins float low and every register starts at zero
  task automatic t_reset;
    rd(c_dat, 32'h0);
    rd(d_dat, 32'h0);
    rd(c_dir, 32'h0);
    rd(d_dir, 32'h0);
    chk(32'({pc_oe, pd_oe}), 32'h0);
  endtask
  // Mixed directions: readback merges stored bits and synced pins
  task automatic t_gpio_d;
    far_d <= 8'h3c;
    wr(d_dat, 8'ha5);
    @(negedge clk_sys);
    chk(32'(pd_oe), 32'h0);
    @(posedge clk_sys);
    rd(d_dat, 32'h3c);
    wr(d_dir, 8'hf0);
    @(negedge clk_sys);
    chk(32'({pd_oe, pd_out[7:4]}), 32'hf0a);
    @(posedge clk_sys);
    rd(d_dir, 32'hf0);
    rd(d_dat, 32'hac);
  endtask
  task automatic t_gpio_c;
    wr(c_dir, 8'hff);
    rd(c_dir, 32'h3);
    wr(c_dat, 8'h02);
    @(negedge clk_sys);
    chk(32'({pc_oe, pc_out}), 32'he);
    @(posedge clk_sys);
    rd(c_dat, 32'h2);
  endtask
  // Reserved words ignore writes; past them the bus refuses
  task automatic t_rsvd;
    wr(12'h020, 8'hff);
    wr(12'h064, 8'hff);
    rd(12'h020, 32'h0);
    rd(12'h064, 32'h0);
    rd(12'h068, 32'h0, 1'b1);
    rd(d_dir, 32'hf0);
    // Misaligned and left-out words are refused
    rd(12'h011, 32'h0, 1'b1);
    rd(12'h000, 32'h0, 1'b1);
    // A write without byte lane 0 must not land
    pstrb <= 4'h0;
    wr(d_dir, 8'h0f);
    pstrb <= 4'hf;
    rd(d_dir, 32'hf0);
  endtask
  // Link takes the pins wide, then narrow, then hands them back
  task automatic t_link;
    far_c <= 2'h2;
    die_link_enable <= 1'b1;
    die_link_wide_mode <= 1'b1;
    repeat (20) @(posedge clk_sys);
    chk({31'h0, die_link_interrupt}, 32'h1);
    rd(d_dir, 32'hf0);
    rd(c_dir, 32'h3);
    die_link_wide_mode <= 1'b0;
    wr(d_dat, 8'h3c);
    @(negedge clk_sys);
    chk(32'({pd_oe[7:4], pd_out[7:4], die_link_data_in[7:4]}), 32'hf30);
    @(posedge clk_sys);
    die_link_enable <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk(32'({pc_oe, pc_out, pd_oe, die_link_data_in}), 32'hef000);
  endtask
  // Reset in mid-run drops every drive and clears the registers
  task automatic t_mid_reset;
    @(posedge clk_sys);
    nrst <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk(32'({pc_oe, pc_out, pd_oe, pd_out, pready}), 32'h0);
    @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    rd(c_dir, 32'h0);
    rd(d_dir, 32'h0);
    rd(d_dat, 32'h3c);
  endtask
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_gpio_d();
    t_gpio_c();
    t_rsvd();
    t_link();
    t_mid_reset();
    end_sim();
  end
  // Whole run needs some 160 cycles; far more means a hang
  initial begin
    #100us;
    fails++;
    end_sim();
  end
endmodule // die_link_port_pins_tb_top
`default_nettype wire

// ---- sim/die_link_port_properties.sv ----
/* Checker for die_link_port_pins, bound to its ports.
   Assumes APB answers in the second access cycle. */
`default_nettype none
module die_link_port_properties (
  // Clock, reset and APB
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and die link
  input wire logic [1:0] pc_in,
  input wire logic [1:0] pc_out,
  input wire logic [1:0] pc_oe,
  input wire logic pc1_pulldown,
  input wire logic [7:0] pd_oe,
  input wire logic [7:0] pd_pulldown,
  input wire logic die_link_enable,
  input wire logic die_link_wide_mode,
  input wire logic die_link_clock,
  input wire logic [7:0] die_link_data_oe,
  input wire logic [7:0] pd_in,
  input wire logic [7:0] die_link_data_in,
  input wire logic die_link_interrupt
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Setup cycle followed by the first access cycle
  sequence s_req;
    psel && !penable ##1 psel && penable;
  endsequence
  a_apb_answer: assert property (s_req |-> !pready ##1 pready)
    else $error("late bus answer");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready too long");
  a_rsvd_zero: assert property (
    pready && !pwrite && paddr[11:2] inside {[10'h008:10'h019]} && paddr[1:0] == 2'h0
    |-> prdata == 32'h0000_0000 && !pslverr) else $error("reserved read not zero");
  a_clock_fwd: assert property (
    die_link_enable |=> pc_oe[0] && pc_out[0] == $past(die_link_clock))
    else $error("clock not forwarded");
  a_int_input: assert property (
    die_link_enable |=> !pc_oe[1] && pc1_pulldown) else $error("interrupt pin driven");
  a_int_synced: assert property (
    (die_link_enable && $stable(pc_in[1]))[*4] |-> die_link_interrupt == pc_in[1])
    else $error("interrupt not synced");
  a_data_synced: assert property (
    (die_link_enable && die_link_wide_mode && $stable(pd_in))[*4] |-> die_link_data_in == pd_in)
    else $error("link data not synced");
  a_wide_dir: assert property (
    die_link_enable && die_link_wide_mode |=> pd_oe == $past(die_link_data_oe)
    && pd_pulldown == ~$past(die_link_data_oe)) else $error("wide pins wrong");
  a_narrow_dir: assert property (
    die_link_enable && !die_link_wide_mode |=> pd_oe[3:0] == $past(die_link_data_oe[3:0])
    && pd_pulldown[7:4] == 4'h0) else $error("narrow pins wrong");
endmodule // die_link_port_properties
bind die_link_port_pins die_link_port_properties u_props (.*);
`default_nettype wire
